// *** hbu_map.vh ***
/*
 * constants for the hardware breakpoint unit: channel count, widths,
 * reset values and state codes.
 * assumes it is included by bare name from the unit's design file.
 */
`ifndef HBU_MAP_VH
`define HBU_MAP_VH

// ****************************************
// channel layout
// ****************************************
`define HBU_NUM_BP 4
`define HBU_NUM_PROBE 4
`define HBU_CNT_W 16
`define HBU_MAX_PASS 16'h7fff
`define HBU_ADDR_W 20
`define HBU_DATA_W 16
`define HBU_CTL_W 3
`define HBU_BLK_SHIFT 8

// ****************************************
// reset values
// ****************************************
`define HBU_CNT_RST 16'h0000
`define HBU_MAP_RST 1'h0

// ****************************************
// run control states
// ****************************************
`define HBU_ST_HALTED 2'h0
`define HBU_ST_RUN 2'h1
`define HBU_ST_STOPPING 2'h2
`define HBU_ST_STEP 2'h3

`endif

// *** hbu_breakpoint_unit.v ***
/*
 * hardware breakpoint unit: four breakpoint channels watching the
 * emulation processor bus, run control (halt, single step), target
 * control-line gating and the internal/external memory map.
 * assumes the emulation processor bus runs on i_clock with one
 * i_bus_cycle pulse per bus cycle and one i_instr_done pulse per
 * completed instruction; probe, target control and remote break
 * pins are asynchronous.
 */
`include "hbu_map.vh"

// Functional notes
// - four independent breakpoint channels, each with own conditions and options
// - pass count up to 32767; break only after that many matches
// - address and data each compare to a value or are don't-care
// - four probe lines compared to a pattern, each line maskable
// - selector chooses instruction fetch or data transfer at the address
// - direction selector limits matching to reads or to writes
// - space selector limits matching to memory or to I/O cycles
// - space selector ignored when the processor has no I/O cycles
// - action selector chooses halt or snapshot with continued execution
// - each breakpoint clears alone; one operation clears them all
// - trigger outputs usable by test equipment
// - triggers feed another emulator; its trigger halts this one too
// - probe lines go to both breakpoint compare and trace capture
// - halt stops user code and reports the next instruction address
// - single step runs exactly one instruction then stops
// - target control lines reach the processor only when enabled
// - accesses reach target memory only in externally mapped regions
// - 256-byte map blocks, all internal after reset
module hbu_breakpoint_unit #(
  parameter AW = `HBU_ADDR_W,
  parameter DW = `HBU_DATA_W,
  parameter CW = `HBU_CTL_W
) (
  // clock and reset
  input wire i_clock,
  input wire i_srst,
  // emulation processor bus
  input wire i_bus_cycle,
  input wire [AW-1:0] i_bus_addr,
  input wire [DW-1:0] i_bus_data,
  input wire i_bus_fetch,
  input wire i_bus_write,
  input wire i_bus_io,
  input wire i_cpu_has_io,
  input wire i_instr_done,
  input wire [AW-1:0] i_next_pc,
  // external probe and remote break pins
  input wire [`HBU_NUM_PROBE-1:0] i_probe,
  input wire i_remote_break,
  // breakpoint configuration, channel n in slice n
  input wire [`HBU_NUM_BP-1:0] i_bp_enable,
  input wire [`HBU_NUM_BP*`HBU_CNT_W-1:0] i_bp_count,
  input wire [`HBU_NUM_BP*AW-1:0] i_bp_addr,
  input wire [`HBU_NUM_BP-1:0] i_bp_addr_dc,
  input wire [`HBU_NUM_BP*DW-1:0] i_bp_data,
  input wire [`HBU_NUM_BP-1:0] i_bp_data_dc,
  input wire [`HBU_NUM_BP*`HBU_NUM_PROBE-1:0] i_bp_probe_val,
  input wire [`HBU_NUM_BP*`HBU_NUM_PROBE-1:0] i_bp_probe_dc,
  input wire [`HBU_NUM_BP-1:0] i_bp_sel_instr,
  input wire [`HBU_NUM_BP-1:0] i_bp_sel_write,
  input wire [`HBU_NUM_BP-1:0] i_bp_sel_io,
  input wire [`HBU_NUM_BP-1:0] i_bp_snapshot,
  input wire [`HBU_NUM_BP-1:0] i_bp_clear,
  input wire i_bp_clear_all,
  // run control requests
  input wire i_go,
  input wire i_halt_req,
  input wire i_step_req,
  // target control lines
  input wire [CW-1:0] i_tgt_ctl,
  input wire [CW-1:0] i_ctl_enable,
  // memory map write port
  input wire i_map_we,
  input wire [AW-`HBU_BLK_SHIFT-1:0] i_map_block,
  input wire i_map_ext,
  // breakpoint status and triggers
  output reg [`HBU_NUM_BP-1:0] o_bp_hit,
  output reg [`HBU_NUM_BP-1:0] o_trigger,
  output reg o_trigger_any,
  output reg o_snapshot,
  output reg [AW-1:0] o_snap_addr,
  output reg [`HBU_NUM_PROBE-1:0] o_trace_probe,
  // run control status
  output reg o_cpu_run,
  output reg o_halted,
  output reg [AW-1:0] o_halt_pc,
  output reg o_step_done,
  // gated control lines and memory routing
  output reg [CW-1:0] o_cpu_ctl,
  output reg o_ext_access
);

  localparam NBLK = 1 << (AW - `HBU_BLK_SHIFT);
  localparam SW = `HBU_NUM_PROBE + CW + 1;

  // ****************************************
  // pin synchronisers
  // ****************************************
  // a change counts only when stages two and three agree, which
  // filters a single-cycle glitch at the cost of one extra cycle
  reg [SW-1:0] sync1_reg;
  reg [SW-1:0] sync2_reg;
  reg [SW-1:0] sync3_reg;
  reg [SW-1:0] pins_reg;
  // bits where stages two and three agree; the others keep their last settled value
  wire [SW-1:0] agree_w = ~(sync2_reg ^ sync3_reg);

  always @(posedge i_clock) begin
    if (i_srst) begin
      sync1_reg <= {SW{1'b0}};
      sync2_reg <= {SW{1'b0}};
      sync3_reg <= {SW{1'b0}};
      pins_reg <= {SW{1'b0}};
    end else begin
      sync1_reg <= {i_remote_break, i_tgt_ctl, i_probe};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      pins_reg <= (pins_reg & ~agree_w) | (sync2_reg & agree_w);
    end
  end

  wire [`HBU_NUM_PROBE-1:0] probe_w = pins_reg[`HBU_NUM_PROBE-1:0];
  wire [CW-1:0] tgt_ctl_w = pins_reg[`HBU_NUM_PROBE+CW-1:`HBU_NUM_PROBE];
  wire remote_w = pins_reg[SW-1];

  // ****************************************
  // breakpoint channels
  // ****************************************
  wire [`HBU_NUM_BP-1:0] fire_w;
  wire [`HBU_NUM_BP-1:0] hit_w;

  genvar g;
  generate
    for (g = 0; g < `HBU_NUM_BP; g = g + 1) begin : ch
      reg [`HBU_CNT_W-1:0] cnt_reg;
      reg hit_reg;
      wire [`HBU_CNT_W-1:0] cnt_inc = cnt_reg + 16'h0001;
      wire [`HBU_NUM_PROBE-1:0] pv = i_bp_probe_val[g*`HBU_NUM_PROBE +: `HBU_NUM_PROBE];
      wire [`HBU_NUM_PROBE-1:0] pdc = i_bp_probe_dc[g*`HBU_NUM_PROBE +: `HBU_NUM_PROBE];
      wire addr_ok = i_bp_addr_dc[g] | (i_bus_addr == i_bp_addr[g*AW +: AW]);
      wire data_ok = i_bp_data_dc[g] | (i_bus_data == i_bp_data[g*DW +: DW]);
      wire probe_ok = ((probe_w ^ pv) & ~pdc) == {`HBU_NUM_PROBE{1'b0}};
      wire kind_ok = (i_bus_fetch == i_bp_sel_instr[g]);
      wire dir_ok = (i_bus_write == i_bp_sel_write[g]);
      wire space_ok = ~i_cpu_has_io | (i_bus_io == i_bp_sel_io[g]);
      // all conditions in the same bus cycle
      wire match = i_bp_enable[g] & i_bus_cycle & addr_ok & data_ok & probe_ok & kind_ok & dir_ok & space_ok;
      wire clr = i_bp_clear[g] | i_bp_clear_all;
      // break on the programmed pass, zero acts as one
      assign fire_w[g] = match & ~hit_reg & (cnt_inc >= i_bp_count[g*`HBU_CNT_W +: `HBU_CNT_W]);
      // a hit in the clearing cycle is kept: set wins over clear
      wire hit_next = fire_w[g] | (hit_reg & ~clr);
      // status shows the flag's next value, so a clear is seen one cycle later, not two
      assign hit_w[g] = hit_next;

      always @(posedge i_clock) begin
        if (i_srst) begin
          cnt_reg <= `HBU_CNT_RST;
          hit_reg <= 1'b0;
        end else begin
          if (clr) begin
            cnt_reg <= `HBU_CNT_RST;
          end else if (match & ~hit_reg) begin
            cnt_reg <= cnt_inc;
          end
          // sticky until cleared
          hit_reg <= hit_next;
        end
      end
    end
  endgenerate

  // ****************************************
  // triggers and snapshot
  // ****************************************
  // split by action
  wire bp_halt_w = |(fire_w & ~i_bp_snapshot);
  wire bp_snap_w = |(fire_w & i_bp_snapshot);

  always @(posedge i_clock) begin
    if (i_srst) begin
      o_bp_hit <= {`HBU_NUM_BP{1'b0}};
      o_trigger <= {`HBU_NUM_BP{1'b0}};
      o_trigger_any <= 1'b0;
      o_snapshot <= 1'b0;
      o_snap_addr <= {AW{1'b0}};
      o_trace_probe <= {`HBU_NUM_PROBE{1'b0}};
    end else begin
      o_bp_hit <= hit_w;
      // trigger pulses for scopes or other emulators
      o_trigger <= fire_w;
      o_trigger_any <= |fire_w;
      o_snapshot <= bp_snap_w;
      if (bp_snap_w) begin
        o_snap_addr <= i_bus_addr;
      end
      o_trace_probe <= probe_w;
    end
  end

  // ****************************************
  // run control
  // ****************************************
  reg [1:0] state_reg;
  reg [1:0] state_next;
  // each state listens only to the requests that can move it; the rest are ignored
  // a remote trigger stops this emulator with the rest
  wire stop_w = i_halt_req | bp_halt_w | remote_w;

  always @* begin
    state_next = state_reg;
    case (state_reg)
      `HBU_ST_HALTED: begin
        if (i_step_req) begin
          state_next = `HBU_ST_STEP;
        end else if (i_go) begin
          state_next = `HBU_ST_RUN;
        end
      end
      `HBU_ST_RUN: begin
        // stop lands on an instruction boundary
        if (stop_w) begin
          state_next = i_instr_done ? `HBU_ST_HALTED : `HBU_ST_STOPPING;
        end
      end
      `HBU_ST_STOPPING: begin
        if (i_instr_done) begin
          state_next = `HBU_ST_HALTED;
        end
      end
      `HBU_ST_STEP: begin
        if (i_instr_done) begin
          state_next = `HBU_ST_HALTED;
        end
      end
      default: begin
        state_next = `HBU_ST_HALTED;
      end
    endcase
  end

  wire enter_halt_w = (state_next == `HBU_ST_HALTED) & (state_reg != `HBU_ST_HALTED);

  always @(posedge i_clock) begin
    if (i_srst) begin
      state_reg <= `HBU_ST_HALTED;
      o_cpu_run <= 1'b0;
      o_halted <= 1'b1;
      o_halt_pc <= {AW{1'b0}};
      o_step_done <= 1'b0;
    end else begin
      state_reg <= state_next;
      o_cpu_run <= (state_next != `HBU_ST_HALTED);
      o_halted <= (state_next == `HBU_ST_HALTED);
      if (enter_halt_w) begin
        o_halt_pc <= i_next_pc;
      end
      o_step_done <= enter_halt_w & (state_reg == `HBU_ST_STEP);
    end
  end

  // ****************************************
  // control lines and memory map
  // ****************************************
  // a flat vector rather than a memory so that reset can clear it at once
  reg [NBLK-1:0] map_reg;

  always @(posedge i_clock) begin
    if (i_srst) begin
      map_reg <= {NBLK{`HBU_MAP_RST}};
      o_cpu_ctl <= {CW{1'b0}};
      o_ext_access <= 1'b0;
    end else begin
      if (i_map_we) begin
        map_reg[i_map_block] <= i_map_ext;
      end
      o_cpu_ctl <= tgt_ctl_w & i_ctl_enable;
      // a map write and a bus cycle in one cycle route by the old map bit
      // route to target only for external blocks
      o_ext_access <= i_bus_cycle & map_reg[i_bus_addr[AW-1:`HBU_BLK_SHIFT]];
    end
  end

endmodule

// *** hbu_breakpoint_unit_properties.sv ***
/* concurrent checks on the breakpoint unit ports.
   assumes a bind onto hbu_breakpoint_unit, one clock i_clock. */
module hbu_checker #(
  parameter CW = 3
) (
  // clock, reset and watched inputs
  input wire i_clock,
  input wire i_srst,
  input wire i_bus_cycle,
  input wire i_go,
  input wire i_step_req,
  input wire [3:0] i_bp_clear,
  input wire i_bp_clear_all,
  input wire [CW-1:0] i_ctl_enable,
  // watched outputs
  input wire [3:0] o_bp_hit,
  input wire [3:0] o_trigger,
  input wire o_trigger_any,
  input wire o_snapshot,
  input wire o_cpu_run,
  input wire o_halted,
  input wire o_step_done,
  input wire [CW-1:0] o_cpu_ctl,
  input wire o_ext_access
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // properties
  // ****
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_srst);
  any_trigger_a: assert property (o_trigger_any == |o_trigger)
    else $error("trigger summary wrong");
  trig_hit_a: assert property ((o_bp_hit & o_trigger) == o_trigger)
    else $error("trigger without hit");
  hit_sticky_a: assert property (o_bp_hit[0] && !i_bp_clear[0] && !i_bp_clear_all |=> o_bp_hit[0])
    else $error("hit lost without clear");
  clear_all_a: assert property (i_bp_clear_all && !i_bus_cycle |=> o_bp_hit == 4'h0)
    else $error("clear all left a hit");
  no_cycle_a: assert property (!i_bus_cycle |=> o_trigger == 4'h0 && !o_snapshot && !o_ext_access)
    else $error("event without bus cycle");
  ctl_gate_a: assert property ((i_ctl_enable == 0)[*3] |-> o_cpu_ctl == 0)
    else $error("disabled line passed");
  run_excl_a: assert property (!(o_cpu_run && o_halted))
    else $error("run and halted together");
  step_done_a: assert property (o_step_done |-> o_halted && $past(o_cpu_run))
    else $error("step done without run");
  halt_hold_a: assert property (o_halted && !i_go && !i_step_req |=> o_halted)
    else $error("left halt without request");
endmodule

bind hbu_breakpoint_unit hbu_checker #(.CW(CW)) i_hbu_checker (.*);

// *** hbu_bus_model.sv ***
/* partner model: emulation processor bus cycles and instruction stream.
   assumes requests change just after the rising edge. */
module hbu_bus_model (
  // clock and run state
  input wire i_clock,
  input wire i_run,
  // requested bus cycle, kind is fetch, write, io
  input wire i_req,
  input wire [19:0] i_addr,
  input wire [15:0] i_data,
  input wire [2:0] i_kind,
  // processor pins
  output wire o_cycle,
  output wire [19:0] o_addr,
  output wire [15:0] o_data,
  output wire [2:0] o_kind,
  output logic o_done = 1'b0,
  output logic [19:0] o_pc = 20'h00500
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [19:0] la = 20'h0;
  logic [15:0] ld = 16'h0;
  logic [2:0] lk = 3'h0;
  logic [1:0] ph = 2'h0;
  // released pins invert, so a stale value never matches by luck
  assign o_cycle = i_req;
  assign o_addr = i_req ? i_addr : ~la;
  assign o_data = i_req ? i_data : ~ld;
  assign o_kind = i_req ? i_kind : ~lk;
  // one instruction done every four cycles while allowed to run
  always @(posedge i_clock) begin
    if (i_req) begin
      la <= i_addr;
      ld <= i_data;
      lk <= i_kind;
    end
    #1 o_done = 1'b0;
    ph = i_run ? ph + 2'h1 : 2'h0;
    if (ph == 2'h3) begin
      o_done = 1'b1;
      o_pc = o_pc + 20'h2;
    end
  end
endmodule

// *** test_hbu_breakpoint_unit.sv ***
/* self-checking bench for hbu_breakpoint_unit.
   assumes hbu_bus_model plays the processor; seed fixed. */
module test_hbu_breakpoint_unit;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clock = 0, i_srst = 1, i_cpu_has_io = 1, i_remote_break = 0, i_bp_clear_all = 0, rq = 0;
  logic i_go = 0, i_halt_req = 0, i_step_req = 0, i_map_we = 0, i_map_ext = 0;
  logic [3:0] i_probe = 0, i_bp_enable = 0, i_bp_addr_dc = 0, i_bp_data_dc = 0, i_bp_sel_instr = 0;
  logic [3:0] i_bp_sel_write = 0, i_bp_sel_io = 0, i_bp_snapshot = 0, i_bp_clear = 0, eh, m;
  logic [63:0] i_bp_count = 0, i_bp_data = 0;
  logic [79:0] i_bp_addr = 0;
  logic [15:0] i_bp_probe_val = 0, i_bp_probe_dc = 0, d;
  logic [2:0] i_tgt_ctl = 0, i_ctl_enable = 0, k;
  logic [11:0] i_map_block = 0;
  logic [19:0] a, last_pc = 0;
  wire i_bus_cycle, i_bus_fetch, i_bus_write, i_bus_io, i_instr_done, o_trigger_any, o_snapshot;
  wire o_cpu_run, o_halted, o_step_done, o_ext_access;
  wire [19:0] i_bus_addr, i_next_pc, o_snap_addr, o_halt_pc;
  wire [15:0] i_bus_data;
  wire [3:0] o_bp_hit, o_trigger, o_trace_probe;
  wire [2:0] o_cpu_ctl;
  int miscompares = 0, checked = 0, dones = 0, n;
  always #25 i_clock = ~i_clock;
  always @(posedge i_clock) if (i_instr_done === 1'b1) begin
    last_pc <= i_next_pc;
    dones <= dones + 1;
  end
  hbu_breakpoint_unit i_hbu_breakpoint_unit (.*);
  hbu_bus_model i_hbu_bus_model (.i_clock(i_clock), .i_run(o_cpu_run), .i_req(rq), .i_addr(a), .i_data(d),
    .i_kind(k), .o_cycle(i_bus_cycle), .o_addr(i_bus_addr), .o_data(i_bus_data),
    .o_kind({i_bus_fetch, i_bus_write, i_bus_io}), .o_done(i_instr_done), .o_pc(i_next_pc));
  // ****
  // helpers
  // ****
  task chk(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task tick(input int c = 1);
    repeat (c) @(posedge i_clock);
    #1;
  endtask
  // bus request stays up, so back to back cycles need no gap
  task cyc(input logic [19:0] ca, input logic [2:0] ck);
    rq = 1;
    a = ca;
    k = ck;
    tick();
  endtask
  task hold_halt();
    for (int t = 0; t < 20 && o_halted !== 1'b1; t++) tick();
  endtask
  task clr_all();
    i_bp_clear_all = 1;
    tick();
    i_bp_clear_all = 0;
    eh = 0;
  endtask
  function automatic logic [3:0] mt(input logic [19:0] ma, input logic [15:0] md, input logic [2:0] mk);
    for (int c = 0; c < 4; c++)
      mt[c] = i_bp_enable[c] && (i_bp_addr_dc[c] || ma == i_bp_addr[c*20+:20])
        && (i_bp_data_dc[c] || md == i_bp_data[c*16+:16]) && mk[2] == i_bp_sel_instr[c]
        && (((i_probe ^ i_bp_probe_val[c*4+:4]) & ~i_bp_probe_dc[c*4+:4]) == 4'h0)
        && mk[1] == i_bp_sel_write[c] && (!i_cpu_has_io || mk[0] == i_bp_sel_io[c]);
  endfunction
  task wrap_up();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    #3000000 miscompares++;
    wrap_up();
  end
  // ****
  // tests
  // ****
  initial begin
    void'($urandom(32'hc94fe07f));
    d = 0;
    tick(6);
    i_srst = 0;
    chk({o_halted, o_bp_hit}, 5'h10);
    cyc($urandom, 0);
    chk(o_ext_access, 0);
    rq = 0;
    i_map_we = 1;
    i_map_block = a[19:8];
    i_map_ext = 1;
    i_probe = $urandom;
    tick();
    i_map_we = 0;
    cyc(a ^ 20'h000ff, 0);
    chk(o_ext_access, 1);
    cyc(a ^ 20'h00100, 0);
    chk(o_ext_access, 0);
    rq = 0;
    tick(8);
    chk(o_trace_probe, i_probe);
    for (int j = 0; j < 5; j++) begin
      i_tgt_ctl = $urandom;
      i_ctl_enable = j == 0 ? 3'h0 : 3'($urandom);
      tick(8);
      chk(o_cpu_ctl, i_tgt_ctl & i_ctl_enable);
    end
    repeat (8) begin
      clr_all();
      chk(o_bp_hit, 0);
      i_bp_enable = $urandom;
      i_bp_count = {$urandom, $urandom} & 64'h0001000100010001;
      i_bp_addr = 80'({$urandom, $urandom, $urandom});
      i_bp_data = {$urandom, $urandom};
      {i_bp_addr_dc, i_bp_data_dc, i_bp_sel_instr, i_bp_sel_write, i_bp_sel_io, i_bp_snapshot} = $urandom;
      i_bp_probe_val = {4{i_probe}} ^ 16'($urandom & $urandom);
      i_bp_probe_dc = $urandom;
      i_cpu_has_io = $urandom;
      repeat (40) begin
        n = $urandom % 4;
        d = i_bp_data[n*16+:16] ^ 16'($urandom % 4 == 0);
        k = {i_bp_sel_instr[n], i_bp_sel_write[n], i_bp_sel_io[n]} ^ 3'($urandom % 8 < 2 ? 1 << ($urandom % 3) : 0);
        a = i_bp_addr[n*20+:20] ^ 20'($urandom % 4 == 0);
        m = mt(a, d, k);
        cyc(a, k);
        chk(o_trigger, m & ~eh);
        chk(o_trigger_any, |(m & ~eh));
        chk(o_snapshot, |(m & ~eh & i_bp_snapshot));
        if (|(m & ~eh & i_bp_snapshot)) chk(o_snap_addr, a);
        eh = eh | m;
        chk(o_bp_hit, eh);
      end
      rq = 0;
      i_bp_clear = $urandom;
      tick();
      eh = eh & ~i_bp_clear;
      i_bp_clear = 0;
      chk(o_bp_hit, eh);
    end
    clr_all();
    {i_bp_enable, i_bp_addr_dc, i_bp_data_dc, i_bp_sel_instr, i_bp_sel_write, i_bp_sel_io} = 24'h133000;
    {i_bp_probe_dc, i_bp_count, i_bp_snapshot} = {16'hffff, 64'h7fff, 4'h1};
    repeat (32766) cyc(0, 0);
    chk(o_bp_hit, 0);
    cyc(0, 0);
    chk(o_trigger, 1);
    rq = 0;
    clr_all();
    i_bp_enable = 4'h3;
    i_bp_count = 0;
    i_bp_sel_write = 4'h2;
    i_go = 1;
    tick();
    i_go = 0;
    chk(o_cpu_run, 1);
    cyc(0, 0);
    chk({o_snapshot, o_cpu_run}, 2'h3);
    cyc(0, 3'h2);
    rq = 0;
    hold_halt();
    chk(o_halted, 1);
    i_go = 1;
    tick();
    i_go = 0;
    tick(6);
    i_halt_req = 1;
    hold_halt();
    i_halt_req = 0;
    chk({o_halted, o_halt_pc}, {1'b1, last_pc});
    n = dones;
    i_step_req = 1;
    tick();
    i_step_req = 0;
    for (int t = 0; t < 20 && o_step_done !== 1'b1; t++) tick();
    chk({o_step_done, o_halted, o_halt_pc}, {2'h3, last_pc});
    chk(dones - n, 1);
    i_go = 1;
    tick();
    i_go = 0;
    tick(3);
    i_remote_break = 1;
    hold_halt();
    i_remote_break = 0;
    chk(o_halted, 1);
    wrap_up();
  end
endmodule
